/* File: logic/clock_glitchless_mux.sv */
// Glitch-free two-input clock switch cell.
// Assumes both clocks run while a switch is in progress.
module clock_glitchless_mux (
    input wire logic i_rst_n,
    input wire logic i_clk_a,
    input wire logic i_clk_b,
    input wire logic i_select_b,
    output logic o_clock
);
    logic a_meta, a_on, b_meta, b_on;

    // Each side takes over only after the other has stopped, so no pulse
    // shorter than either source can reach the output.
    always_ff @(negedge i_clk_a or negedge i_rst_n) begin
        if (!i_rst_n) begin
            a_meta <= 1'b1;
            a_on <= 1'b1;
        end else begin
            a_meta <= !i_select_b && !b_on;
            a_on <= a_meta;
        end
    end

    always_ff @(negedge i_clk_b or negedge i_rst_n) begin
        if (!i_rst_n) begin
            b_meta <= 1'b0;
            b_on <= 1'b0;
        end else begin
            b_meta <= i_select_b && !a_on;
            b_on <= b_meta;
        end
    end

    assign o_clock = (i_clk_a && a_on) || (i_clk_b && b_on);
endmodule

/* File: logic/clock_select_pkg.sv */
// Constants, register layout and types for the system clock selector.
// Assumes an SFR-style write/read port driven by the core on i_clock.
package clock_select_pkg;
    localparam logic [7:0] clock_source_register_addr = 8'h8f;
    localparam logic [7:0] internal_osc_control_addr = 8'ha1;
    localparam logic [7:0] coarse_trim_addr = 8'ha2;
    localparam logic [7:0] fine_trim_addr = 8'h9e;
    localparam logic [7:0] clock_source_reset = 8'h00;
    localparam logic [7:0] internal_osc_control_reset = 8'hc0;
    // Trim defaults stand in for factory values; the figures are arbitrary.
    localparam logic [6:0] coarse_trim_reset = 7'h40;
    localparam logic [5:0] fine_trim_reset = 6'h20;
    localparam int suspend_bit = 5;
    localparam int ready_bit = 4;
    localparam logic [1:0] osc_enable_on = 2'h3;
    localparam logic [1:0] osc_enable_off = 2'h0;
    typedef enum logic [1:0] {
        src_internal = 2'h0,
        src_external = 2'h1,
        src_multiplier = 2'h2,
        src_reserved = 2'h3
    } source_t;
endpackage

/* File: logic/system_clock_select_and_suspend.sv */
// Clock source selection, internal divider, trim and suspend control.
// Assumes the core's register port is synchronous to i_clock and that the
// oscillator clocks come in as ports from the analog cells.
module system_clock_select_and_suspend
    import clock_select_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_int_osc_clock,
    input wire logic i_ext_osc_clock,
    input wire logic i_mult_clock,
    input wire logic i_crystal_settled,
    input wire logic i_int_osc_stable,
    input wire logic [3:0] i_port_match,
    input wire logic i_comparator_enabled,
    input wire logic i_comparator_out,
    input wire logic i_reg_write,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_crystal_valid_flag,
    output logic o_int_osc_run,
    output logic [6:0] o_coarse_trim,
    output logic [5:0] o_fine_trim,
    output logic o_periph_ext_clock,
    output logic o_system_clock_signal
);
    import clock_select_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta, rst_n;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0] source_select_field;
    logic [1:0] internal_osc_enable_field;
    logic suspend;
    logic [2:0] internal_divider_field;
    logic [6:0] coarse_trim;
    logic [5:0] fine_trim;
    logic frequency_ready_flag;

    wire wr_source = i_reg_write && i_reg_addr == clock_source_register_addr;
    wire wr_osc = i_reg_write && i_reg_addr == internal_osc_control_addr;
    wire wr_coarse = i_reg_write && i_reg_addr == coarse_trim_addr;
    wire wr_fine = i_reg_write && i_reg_addr == fine_trim_addr;
    wire wake_event = |i_port_match
        || (i_comparator_enabled && !i_comparator_out);
    wire [1:0] w_src = i_reg_wdata[1:0];
    wire [1:0] w_en = i_reg_wdata[7:6];
    // Reserved enable codes are treated as a refused write of that field.
    wire en_legal = w_en == osc_enable_on || w_en == osc_enable_off;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            source_select_field <= clock_source_reset[1:0];
            internal_osc_enable_field <= internal_osc_control_reset[7:6];
            suspend <= 1'b0;
            internal_divider_field <= internal_osc_control_reset[2:0];
            coarse_trim <= coarse_trim_reset;
            fine_trim <= fine_trim_reset;
        end else begin
            if (wr_source && w_src != src_reserved)
                source_select_field <= w_src;
            if (wr_osc) begin
                if (en_legal)
                    internal_osc_enable_field <= w_en;
                internal_divider_field <= i_reg_wdata[2:0];
            end
            // Wake outranks a new suspend write in the same cycle.
            // Waking only lets the clock run on; no other state is touched,
            // so the core carries on right after its suspending write.
            if (wake_event)
                suspend <= 1'b0;
            else if (wr_osc && i_reg_wdata[suspend_bit])
                suspend <= 1'b1;
            if (wr_coarse)
                coarse_trim <= i_reg_wdata[6:0];
            if (wr_fine)
                fine_trim <= i_reg_wdata[5:0];
        end
    end

    // Enabled, not suspended: runs the cycle after the enabling write.
    assign o_int_osc_run = internal_osc_enable_field == osc_enable_on
        && !suspend;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n)
            frequency_ready_flag <= 1'b0;
        else
            frequency_ready_flag <= o_int_osc_run && i_int_osc_stable;
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n)
            o_crystal_valid_flag <= 1'b0;
        else
            o_crystal_valid_flag <= i_crystal_settled;
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [7:0] osc_read = {internal_osc_enable_field, suspend,
        frequency_ready_flag, 1'b0, internal_divider_field};
    wire [7:0] read_value =
        i_reg_addr == clock_source_register_addr ?
            {6'h00, source_select_field} :
        i_reg_addr == internal_osc_control_addr ? osc_read :
        i_reg_addr == coarse_trim_addr ? {1'b0, coarse_trim} :
        i_reg_addr == fine_trim_addr ? {2'h0, fine_trim} : 8'h00;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n)
            o_reg_rdata <= 8'h00;
        else
            o_reg_rdata <= read_value;
    end

    assign o_coarse_trim = coarse_trim;
    assign o_fine_trim = fine_trim;

    // ------------------------------------------------------------
    // Internal divider on the oscillator clock
    // ------------------------------------------------------------
    // Divide ratio: codes 000..111 give 128,64,32,16,8,4,4,1.
    logic [6:0] div_count;
    logic int_div_clock;
    logic [2:0] div_code_meta, div_code_sync, div_code_hold, div_code;
    wire [6:0] half_limit =
        div_code == 3'h0 ? 7'h3f : div_code == 3'h1 ? 7'h1f :
        div_code == 3'h2 ? 7'h0f : div_code == 3'h3 ? 7'h07 :
        div_code == 3'h4 ? 7'h03 : 7'h01;

    always_ff @(posedge i_int_osc_clock or negedge rst_n) begin
        if (!rst_n) begin
            div_code_meta <= internal_osc_control_reset[2:0];
            div_code_sync <= internal_osc_control_reset[2:0];
            div_code_hold <= internal_osc_control_reset[2:0];
            div_code <= internal_osc_control_reset[2:0];
            div_count <= 7'h00;
            int_div_clock <= 1'b0;
        end else begin
            div_code_meta <= internal_divider_field;
            div_code_sync <= div_code_meta;
            div_code_hold <= div_code_sync;
            // The code crosses as three loose bits; it is taken only once
            // two samples in a row agree, so a half-arrived code never
            // sets the divide ratio.
            if (div_code_sync == div_code_hold)
                div_code <= div_code_sync;
            if (div_count >= half_limit) begin
                div_count <= 7'h00;
                int_div_clock <= !int_div_clock;
            end else begin
                div_count <= div_count + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Suspend gate on the oscillator side
    // ------------------------------------------------------------
    // The run level is retimed to the oscillator's falling edge and the gate
    // moves only while the selected internal clock is low, so entering or
    // leaving suspend never cuts a pulse short. A suspended oscillator stops
    // by itself; the gate covers a cell that is slow to stop.
    logic gate_meta, gate_open;
    wire int_path_low = div_code == 3'h7 || !int_div_clock;

    always_ff @(negedge i_int_osc_clock or negedge rst_n) begin
        if (!rst_n) begin
            gate_meta <= 1'b1;
            gate_open <= 1'b1;
        end else begin
            gate_meta <= o_int_osc_run;
            if (int_path_low)
                gate_open <= gate_meta;
        end
    end

    // Divide-by-1 passes the raw oscillator.
    wire int_sys_clock = gate_open ?
        (div_code == 3'h7 ? i_int_osc_clock : int_div_clock) : 1'b0;

    // ------------------------------------------------------------
    // Source switching
    // ------------------------------------------------------------
    // The multiplier's base and scaling are set in its own cell; here its
    // output is only one more source to pick from.
    logic ext_mult_stage;
    clock_glitchless_mux u_pick_far (
        .i_rst_n(rst_n),
        .i_clk_a(i_ext_osc_clock),
        .i_clk_b(i_mult_clock),
        .i_select_b(source_select_field == src_multiplier),
        .o_clock(ext_mult_stage)
    );
    clock_glitchless_mux u_pick_sys (
        .i_rst_n(rst_n),
        .i_clk_a(int_sys_clock),
        .i_clk_b(ext_mult_stage),
        .i_select_b(source_select_field != src_internal),
        .o_clock(o_system_clock_signal)
    );

    // Timers and the counter array keep the external clock whatever the
    // system clock runs from.
    assign o_periph_ext_clock = i_ext_osc_clock;
endmodule

/* File: tb/clock_select_checker.sv */
// Port assertions for the clock selector.
// Assumes it is bound to the top module and sees its ports only.
module clock_select_checker
    import clock_select_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_ext_osc_clock,
    input wire logic i_crystal_settled,
    input wire logic [3:0] i_port_match,
    input wire logic i_comparator_enabled,
    input wire logic i_comparator_out,
    input wire logic i_reg_write,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_crystal_valid_flag,
    input wire logic o_int_osc_run,
    input wire logic [6:0] o_coarse_trim,
    input wire logic o_periph_ext_clock
);
    timeunit 1ns;
    timeprecision 100ps;
    // The internal reset lags by two flops, so checks wait for live.
    logic [1:0] up;
    logic live, wake, mapped, osc_wr;
    assign live = (up == 2'h3);
    assign wake = (|i_port_match) | (i_comparator_enabled & ~i_comparator_out);
    assign mapped = i_reg_addr inside {8'h8f, 8'ha1, 8'ha2, 8'h9e};
    assign osc_wr = i_reg_write && i_reg_addr == internal_osc_control_addr;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n)
            up <= 2'h0;
        else if (!live)
            up <= up + 2'h1;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence s_enter;
        live && osc_wr && i_reg_wdata[7:5] == 3'h7 && !wake;
    endsequence
    sequence s_wake;
        live && wake && !i_reg_write;
    endsequence
    a_flag_follows: assert property (live |=>
        o_crystal_valid_flag == $past(i_crystal_settled)) else $error("flag");
    a_src_upper_zero: assert property (live && i_reg_addr == 8'h8f
        |=> o_reg_rdata[7:2] == 6'h00) else $error("upper bits");
    a_unmapped_zero: assert property (live && !mapped
        |=> o_reg_rdata == 8'h00) else $error("unmapped");
    a_osc_bit3_zero: assert property (live && i_reg_addr == 8'ha1
        |=> !o_reg_rdata[3]) else $error("bit 3");
    a_suspend_stops: assert property (s_enter |=> !o_int_osc_run)
        else $error("suspend");
    a_wake_restarts: assert property (s_enter ##[1:200] s_wake
        |=> o_int_osc_run) else $error("wake");
    a_periph_ext: assert property (live |->
        o_periph_ext_clock == i_ext_osc_clock) else $error("periph clock");
    a_trim_reset: assert property ($rose(live) |->
        o_coarse_trim == coarse_trim_reset) else $error("trim reset");
    a_trim_write: assert property (live && i_reg_write && i_reg_addr == 8'ha2
        |=> {1'b0, o_coarse_trim} == ($past(i_reg_wdata) & 8'h7f))
        else $error("trim");
    a_no_false_wake: assert property (live && !o_int_osc_run && !wake
        && !osc_wr |=> !o_int_osc_run) else $error("woke without event");
endmodule

/* File: tb/osc_model.sv */
// Stand-ins for the internal and external oscillators and the multiplier.
// Assumes the selector drives i_run high while the internal osc may run.
module osc_model (
    input wire logic i_run,
    output logic o_int_clk,
    output logic o_ext_clk,
    output logic o_mult_clk,
    output logic o_settled,
    output logic o_stable
);
    timeunit 1ns;
    timeprecision 100ps;
    logic free_clk = 1'b0;
    // Edges sit a quarter period off the register clock, so the run level
    // never changes on an oscillator edge.
    initial begin
        #2.5;
        forever #5 free_clk = ~free_clk;
    end
    always #15 o_ext_clk = ~o_ext_clk;
    always #7 o_mult_clk = ~o_mult_clk;
    // A stopped oscillator sits low instead of running on unseen.
    assign o_int_clk = free_clk & i_run;
    assign o_stable = i_run;
    initial begin
        o_ext_clk = 1'b0;
        o_mult_clk = 1'b0;
        o_settled = 1'b0;
        #500000;
        o_settled = 1'b1;
    end
endmodule

/* File: tb/system_clock_select_and_suspend_bench.sv */
// Self-checking bench for the system clock selector.
// Assumes the package is compiled first and osc_model drives the sources.
module system_clock_select_and_suspend_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import clock_select_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r; int p;} row_t;
    logic i_clock, i_rst_n, i_reg_write, i_comparator_enabled, run, stable;
    logic i_comparator_out;
    logic int_clk, ext_clk, mult_clk, settled, o_crystal_valid_flag;
    logic o_int_osc_run, o_periph_ext_clock, o_system_clock_signal;
    logic [3:0] i_port_match;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [6:0] o_coarse_trim;
    logic [5:0] o_fine_trim;
    int n_mismatch = 0;
    int check_count = 0;
    int sys_edges = 0;
    int edges0;
    always @(posedge o_system_clock_signal) sys_edges++;
    row_t rows [13] = '{'{8'ha2, 8'hd5, 8'h55, 1280},
        '{8'ha1, 8'hc0, 8'hd0, 1280}, '{8'ha1, 8'hc1, 8'hd1, 640},
        '{8'ha1, 8'hc2, 8'hd2, 320}, '{8'ha1, 8'hc3, 8'hd3, 160},
        '{8'ha1, 8'hc4, 8'hd4, 80}, '{8'ha1, 8'hc5, 8'hd5, 40},
        '{8'ha1, 8'hc6, 8'hd6, 40}, '{8'ha1, 8'hcf, 8'hd7, 10},
        '{8'h8f, 8'hfd, 8'h01, 30}, '{8'h8f, 8'hff, 8'h01, 30},
        '{8'h8f, 8'h02, 8'h02, 14}, '{8'h8f, 8'h00, 8'h00, 10}};
    system_clock_select_and_suspend DUT (.i_clock, .i_rst_n,
        .i_int_osc_clock(int_clk), .i_ext_osc_clock(ext_clk),
        .i_mult_clock(mult_clk), .i_crystal_settled(settled),
        .i_int_osc_stable(stable), .i_port_match, .i_comparator_enabled,
        .i_comparator_out, .i_reg_write, .i_reg_addr, .i_reg_wdata,
        .o_reg_rdata, .o_crystal_valid_flag, .o_int_osc_run(run),
        .o_coarse_trim, .o_fine_trim, .o_periph_ext_clock,
        .o_system_clock_signal);
    osc_model osc (.i_run(run), .o_int_clk(int_clk), .o_ext_clk(ext_clk),
        .o_mult_clk(mult_clk), .o_settled(settled), .o_stable(stable));
    assign o_int_osc_run = run;
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_write = 1'b1;
        @(negedge i_clock);
        i_reg_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clock);
        i_reg_addr = a;
        repeat (2) @(negedge i_clock);
        cmp(16'(o_reg_rdata), 16'(e));
    endtask
    // The mux may need several old-clock edges, so the first two are skipped.
    task automatic per(input int e);
        realtime t0;
        #4000;
        repeat (2) @(posedge o_system_clock_signal);
        t0 = $realtime;
        @(posedge o_system_clock_signal);
        cmp(16'($rtoi($realtime - t0)), 16'(e));
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    initial begin
        #1600000;
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
    initial begin
        {i_rst_n, i_reg_write, i_comparator_enabled, i_comparator_out} = 4'h0;
        {i_port_match, i_reg_addr, i_reg_wdata} = 20'h0;
        repeat (5) @(negedge i_clock);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_clock);
        cmp(16'(o_crystal_valid_flag), 16'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].r);
            per(rows[i].p);
        end
        $display("row table done");
        for (int k = 0; k < 5; k++) begin
            wr(internal_osc_control_addr, 8'he7);
            edges0 = sys_edges;
            repeat (20) @(negedge i_clock);
            cmp(16'(run), 16'h0);
            cmp(16'(sys_edges - edges0), 16'h0);
            i_port_match = (k < 4) ? 4'(1 << k) : 4'h0;
            i_comparator_enabled = (k == 4);
            @(negedge i_clock);
            {i_port_match, i_comparator_enabled} = 5'h0;
            @(negedge i_clock);
            cmp(16'(run), 16'h1);
        end
        wr(internal_osc_control_addr, 8'he7);
        {i_comparator_enabled, i_comparator_out} = 2'h3;
        repeat (3) @(negedge i_clock);
        cmp(16'(run), 16'h0);
        i_comparator_out = 1'b0;
        @(negedge i_clock);
        i_comparator_enabled = 1'b0;
        @(negedge i_clock);
        cmp(16'(run), 16'h1);
        $display("suspend and wake done");
        repeat (50000) @(negedge i_clock);
        cmp(16'(o_crystal_valid_flag), 16'h1);
        i_rst_n = 1'b0;
        @(negedge i_clock);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_clock);
        cmp(16'(o_coarse_trim), 16'(coarse_trim_reset));
        cmp(16'(o_fine_trim), 16'(fine_trim_reset));
        rd(clock_source_register_addr, 8'h00);
        rd(internal_osc_control_addr, 8'hd0);
        per(1280);
        $display("second reset done");
        conclude();
    end
endmodule
bind system_clock_select_and_suspend clock_select_checker chk (.i_clock,
    .i_rst_n, .i_ext_osc_clock, .i_crystal_settled, .i_port_match,
    .i_comparator_enabled, .i_comparator_out, .i_reg_write, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_crystal_valid_flag, .o_int_osc_run,
    .o_coarse_trim, .o_periph_ext_clock);
